// [verilog/sms_pkg.sv]
// ==========================================================
// timing
package sms_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int BAUD_BPS = 1200;
    localparam int BAUD_CYC = CLK_HZ / BAUD_BPS;
    localparam int MS_CYC = CLK_HZ / 1000;
    localparam int BREAK_MS = 12;
    localparam int MARK_MS = 9;
    localparam int REPLY_TMO_MS = 1000;
    localparam int SEC_MS = 1000;
    localparam int WARM_STEP_MS = 250;
    localparam int WARM_MAX_MS = 63750;
    // ==========================================================
    // register offsets and fields
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_FIFO = 8'h08;
    localparam logic [7:0] A_CFG0 = 8'h10;
    localparam int CTRL_START = 0;
    localparam int CTRL_CH = 4;
    localparam int CFG_ADDR = 0;
    localparam int CFG_WARM = 4;
    localparam int CFG_DIG = 12;
    localparam int CFG_CONC = 16;
    localparam int CFG_IDX = 20;
    localparam logic [3:0] CFG_ADDR_RST = 4'h0;
    localparam logic [7:0] CFG_WARM_RST = 8'h00;
    localparam logic [3:0] CFG_DIG_RST = 4'h0;
    localparam logic [3:0] CFG_IDX_RST = 4'h1;
    localparam logic [3:0] ADDR_MAX = 4'h9;
    localparam logic [3:0] DIG_MAX = 4'h9;
    // ==========================================================
    // line characters
    localparam logic [6:0] CH_ZERO = 7'h30;
    localparam logic [6:0] CH_NINE = 7'h39;
    localparam logic [6:0] CH_M = 7'h4d;
    localparam logic [6:0] CH_C = 7'h43;
    localparam logic [6:0] CH_D = 7'h44;
    localparam logic [6:0] CH_BANG = 7'h21;
    localparam logic [6:0] CH_PLUS = 7'h2b;
    localparam logic [6:0] CH_MINUS = 7'h2d;
    localparam logic [6:0] CH_LF = 7'h0a;
    // ==========================================================
    // sequencer states
    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_BRK = 4'h1,
        S_MARK = 4'h2,
        S_SEND = 4'h3,
        S_RECV = 4'h4,
        S_WAIT = 4'h5,
        S_STORE = 4'h6,
        S_PWR = 4'h7
    } sms_state_t;
endpackage : sms_pkg

// [verilog/sms_fifo.sv]
`timescale 1ns/1ps
module sms_fifo
    import sms_pkg::*;
#(
    parameter int W = 32,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
        $error("fifo depth must be a power of two");
    end
    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wp;
    logic [AW:0] rp;
    // full and empty from pointer wrap bits
    wire do_wr = in_valid && in_ready;
    wire do_rd = out_valid && out_ready;
    assign in_ready = count != (AW+1)'(DEPTH);
    assign out_valid = wp != rp;
    assign count = wp - rp;
    assign out_data = mem[rp[AW-1:0]];
    // pointers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wp <= '0;
            rp <= '0;
        end else begin
            wp <= wp + (AW+1)'(do_wr);
            rp <= rp + (AW+1)'(do_rd);
        end
    end
    // storage
    always_ff @(posedge ref_clk) begin
        if (do_wr) begin
            mem[wp[AW-1:0]] <= in_data;
        end
    end
    no_overflow_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !in_ready |=> count == (AW+1)'(DEPTH) || $past(do_rd)) // RULE12
        else $error("fifo count moved while full");
endmodule : sms_fifo

// [verilog/sms_line.sv]
`timescale 1ns/1ps
module sms_line
    import sms_pkg::*;
#(
    parameter int DIV = BAUD_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // transmit side
    input wire logic [6:0] tx_char,
    input wire logic tx_go,
    output logic tx_rdy,
    input wire logic brk,
    // receive side
    output logic [6:0] rx_char,
    output logic rx_valid,
    // line pin
    input wire logic line_in,
    output logic line_out,
    output logic line_oe_n
);
    localparam int CW = $clog2(DIV + 1);
    if (DIV < 4) begin : g_bad
        $error("baud divider too small");
    end
    // ==========================================================
    // transmit: start, 7 data, even parity, stop
    logic [9:0] tx_sh;
    logic [3:0] tx_n;
    logic [CW-1:0] tx_cnt;
    wire tx_tick = tx_cnt == CW'(DIV - 1);
    assign tx_rdy = tx_n == 4'h0 && !brk;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_sh <= 10'h3ff;
            tx_n <= 4'h0;
            tx_cnt <= '0;
        end else if (tx_go && tx_rdy) begin
            tx_sh <= {1'b1, ^tx_char, tx_char, 1'b0};
            tx_n <= 4'ha;
            tx_cnt <= '0;
        end else if (tx_n != 4'h0) begin
            tx_cnt <= tx_tick ? '0 : tx_cnt + CW'(1);
            if (tx_tick) begin
                tx_sh <= {1'b1, tx_sh[9:1]};
                tx_n <= tx_n - 4'h1;
            end
        end
    end
    // pin drive, released when idle
    assign line_out = brk ? 1'b0 : tx_sh[0];
    assign line_oe_n = !(brk || tx_n != 4'h0);
    // ==========================================================
    // receive: three-stage sync, level accepted when the last two stages agree
    logic s1, s2, s3, filt, filt_q;
    logic [7:0] rx_sh;
    logic [3:0] rx_n;
    logic [CW-1:0] rx_cnt;
    wire rx_idle = rx_n == 4'h0;
    wire rx_fall = filt_q && !filt && rx_idle && line_oe_n;
    wire rx_samp = !rx_idle && rx_cnt == '0;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            {s1, s2, s3, filt, filt_q} <= 5'h1f;
        end else begin
            {s1, s2, s3} <= {line_in, s1, s2};
            filt <= (s2 == s3) ? s3 : filt;
            filt_q <= filt;
        end
    end
    // bit timing, sampled mid-bit
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_n <= 4'h0;
            rx_cnt <= '0;
            rx_sh <= 8'h00;
        end else if (rx_fall) begin
            rx_n <= 4'ha;
            rx_cnt <= CW'(DIV / 2);
        end else if (!rx_idle) begin
            rx_cnt <= rx_samp ? CW'(DIV - 1) : rx_cnt - CW'(1);
            if (rx_samp) begin
                rx_n <= (rx_n == 4'ha && filt) ? 4'h0 : rx_n - 4'h1;
                if (rx_n != 4'ha && rx_n != 4'h1) begin
                    rx_sh <= {filt, rx_sh[7:1]};
                end
            end
        end
    end
    // character out on a good stop bit and parity
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_valid <= 1'b0;
            rx_char <= 7'h00;
        end else begin
            rx_valid <= rx_samp && rx_n == 4'h1 && filt && !(^rx_sh);
            rx_char <= rx_sh[6:0];
        end
    end
    tx_drive_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        tx_go && tx_rdy |=> !line_oe_n && !line_out) // RULE4
        else $error("start bit not driven");
endmodule : sms_line

// [verilog/sms_sequencer.sv]
`timescale 1ns/1ps
// Overview of operation
// RULE1 - each channel's sensor address is accepted only from 0 to 9
// RULE2 - warm-up is 0 to 63750 ms, set in 250 ms steps
// RULE3 - sensor power goes on only when a measurement starts, held through warm-up
// RULE4 - measurement command M0..M9 (or C) sent to the addressed sensor
// RULE5 - the sensor starts measuring and replying on that command
// RULE6 - the sensor first acknowledges with its measurement delay
// RULE7 - after that delay, D commands fetch data until all values arrive
// RULE8 - the value set may differ per numbered measurement command
// RULE9 - only the value at the reading index is kept, index 1 is first
// RULE10 - sensors sharing a bus each have their own address
// RULE11 - sensors usually answer at address zero by default
// RULE12 - each channel has its own settings and its own tag in recording
// RULE13 - power off after transfer end or warm-up end, whichever is later
// RULE14 - fewer values than the reading index marks the record invalid
module sms_sequencer
    import sms_pkg::*;
#(
    parameter int NCH = 4,
    parameter int CLK_PER_MS = MS_CYC,
    parameter int BAUD_DIV = BAUD_CYC,
    parameter int FIFO_DEPTH = 32
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // sensor bus
    input wire logic sdi_in,
    output logic sdi_out,
    output logic sdi_oe_n,
    output logic sensor_pwr
);
    localparam int MSW = $clog2(CLK_PER_MS);
    if (NCH < 1 || NCH > 4 || CLK_PER_MS < 2) begin : g_bad
        $error("channel count or ms divider out of range");
    end
    // ==========================================================
    // channel configuration
    logic [3:0] cfg_addr [NCH];
    logic [7:0] cfg_warm [NCH];
    logic [3:0] cfg_dig [NCH];
    logic cfg_conc [NCH];
    logic [3:0] cfg_idx [NCH];
    // register decode
    wire [1:0] cfg_sel = reg_addr[3:2];
    wire cfg_hit = reg_addr[7:4] == A_CFG0[7:4] && 32'(cfg_sel) < NCH;
    wire wr_ctrl = reg_wr && reg_addr == A_CTRL;
    wire rd_fifo = reg_rd && reg_addr == A_FIFO;
    wire [1:0] w_ch = reg_wdata[CTRL_CH +: 2];
    wire [3:0] w_addr = reg_wdata[CFG_ADDR +: 4];
    wire [3:0] w_dig = reg_wdata[CFG_DIG +: 4];
    genvar gi;
    for (gi = 0; gi < NCH; gi++) begin : g_cfg
        wire we = reg_wr && cfg_hit && cfg_sel == 2'(gi);
        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                cfg_addr[gi] <= CFG_ADDR_RST;
                cfg_warm[gi] <= CFG_WARM_RST;
                cfg_dig[gi] <= CFG_DIG_RST;
                cfg_conc[gi] <= 1'b0;
                cfg_idx[gi] <= CFG_IDX_RST;
            end else if (we) begin
                if (w_addr <= ADDR_MAX) cfg_addr[gi] <= w_addr; // RULE1
                cfg_warm[gi] <= reg_wdata[CFG_WARM +: 8]; // RULE2
                if (w_dig <= DIG_MAX) cfg_dig[gi] <= w_dig; // RULE4
                cfg_conc[gi] <= reg_wdata[CFG_CONC];
                cfg_idx[gi] <= reg_wdata[CFG_IDX +: 4];
            end
        end
    end
    // ==========================================================
    // sequencer state
    sms_state_t state, next_state;
    logic [1:0] cur_ch;
    logic is_d, tmo, sel, neg, got_val, last_inv;
    logic [3:0] dnum;
    logic [2:0] tx_pos;
    logic [4:0] rx_pos;
    logic [9:0] ttt;
    logic [6:0] nexp, vtot;
    logic [23:0] acc;
    logic [19:0] tmr;
    logic [15:0] warm_left;
    logic [MSW-1:0] ms_cnt;
    logic tx_rdy, rx_valid, f_in_ready, f_valid;
    logic [6:0] rx_char, tx_ch;
    logic [31:0] f_data;
    logic [$clog2(FIFO_DEPTH):0] f_cnt;
    // current channel settings
    wire [3:0] c_addr = cfg_addr[cur_ch];
    wire [3:0] c_dig = cfg_dig[cur_ch];
    wire c_conc = cfg_conc[cur_ch];
    wire [3:0] c_idx = cfg_idx[cur_ch];
    // events
    wire ms_tick = ms_cnt == MSW'(CLK_PER_MS - 1);
    wire tmr_done = tmr == 20'h0;
    wire warm_done = warm_left == 16'h0;
    wire wr_start = wr_ctrl && reg_wdata[CTRL_START] && 32'(w_ch) < NCH;
    wire rx_lf = rx_valid && rx_char == CH_LF;
    wire rx_digit = rx_char >= CH_ZERO && rx_char <= CH_NINE;
    wire rx_sign = rx_char == CH_PLUS || rx_char == CH_MINUS;
    wire [3:0] rx_dv = rx_char[3:0];
    wire hit_idx = {3'h0, c_idx} == vtot + 7'h1;
    wire data_done = vtot >= nexp || !got_val || dnum == DIG_MAX; // RULE7
    wire bad = tmo || c_idx == 4'h0 || {3'h0, c_idx} > vtot; // RULE14
    wire push = state == S_STORE && f_in_ready;
    wire [23:0] val = neg ? -acc : acc;
    // ==========================================================
    // command characters: address, M/C/D, digit (left out for M/C with digit 0), '!'
    wire [3:0] dg = is_d ? dnum : c_dig;
    wire skip_dg = !is_d && dg == 4'h0;
    wire [2:0] tx_len = skip_dg ? 3'h3 : 3'h4;
    wire tx_go = state == S_SEND && tx_pos != tx_len;
    wire tx_done = state == S_SEND && tx_pos == tx_len && tx_rdy;
    wire [6:0] op_ch = is_d ? CH_D : (c_conc ? CH_C : CH_M);
    always_comb begin
        case (tx_pos)
            3'h0: tx_ch = CH_ZERO | {3'h0, c_addr};
            3'h1: tx_ch = op_ch; // RULE4
            3'h2: tx_ch = skip_dg ? CH_BANG : (CH_ZERO | {3'h0, dg});
            default: tx_ch = CH_BANG;
        endcase
    end
    // next state
    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: if (wr_start) next_state = S_BRK;
            S_BRK: if (tmr_done) next_state = S_MARK;
            S_MARK: if (tmr_done) next_state = S_SEND;
            S_SEND: if (tx_done) next_state = S_RECV;
            S_RECV: begin
                if (tmr_done) begin
                    next_state = S_STORE;
                end else if (rx_lf && !is_d) begin
                    if (nexp == 7'h0) next_state = S_STORE;
                    else next_state = (ttt == 10'h0) ? S_MARK : S_WAIT; // RULE6
                end else if (rx_lf) begin
                    next_state = data_done ? S_STORE : S_MARK; // RULE7
                end
            end
            S_WAIT: if (tmr_done || (rx_lf && !c_conc)) next_state = S_MARK; // RULE7
            S_STORE: if (push) next_state = S_PWR;
            S_PWR: if (warm_done) next_state = S_IDLE; // RULE13
            default: next_state = S_IDLE;
        endcase
    end
    // timer load per state entry, in ms
    wire entering = next_state != state;
    wire [19:0] tmr_load =
        next_state == S_BRK ? 20'(BREAK_MS + 1) :
        next_state == S_MARK ? 20'(MARK_MS + 1) :
        next_state == S_WAIT ? 20'(ttt * SEC_MS + 1) : 20'(REPLY_TMO_MS);
    // ==========================================================
    // ms divider and timers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ms_cnt <= '0;
            tmr <= 20'h0;
        end else begin
            ms_cnt <= ms_tick ? '0 : ms_cnt + MSW'(1);
            if (entering) tmr <= tmr_load;
            else if (ms_tick && !tmr_done) tmr <= tmr - 20'h1;
        end
    end
    // sensor power and warm-up window
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sensor_pwr <= 1'b0;
            warm_left <= 16'h0;
        end else if (state == S_IDLE && wr_start) begin
            sensor_pwr <= 1'b1; // RULE3
            warm_left <= 16'(cfg_warm[w_ch] * WARM_STEP_MS); // RULE2
        end else begin
            if (ms_tick && !warm_done) warm_left <= warm_left - 16'h1; // RULE3
            if (state == S_PWR && warm_done) sensor_pwr <= 1'b0; // RULE13
        end
    end
    // state and command progress
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= S_IDLE;
            cur_ch <= 2'h0;
            is_d <= 1'b0;
            dnum <= 4'h0;
            tx_pos <= 3'h0;
            tmo <= 1'b0;
            last_inv <= 1'b0;
        end else begin
            state <= next_state;
            if (state == S_IDLE && wr_start) begin
                cur_ch <= w_ch; // RULE12
                is_d <= 1'b0;
                dnum <= 4'h0;
                tmo <= 1'b0;
            end
            if (next_state == S_SEND && entering) tx_pos <= 3'h0;
            else if (tx_go && tx_rdy) tx_pos <= tx_pos + 3'h1;
            if (state == S_RECV && tmr_done) tmo <= 1'b1;
            if (state == S_RECV && rx_lf && !is_d) is_d <= 1'b1;
            if (state == S_RECV && rx_lf && is_d && !data_done) dnum <= dnum + 4'h1;
            if (push) last_inv <= bad;
        end
    end
    // reply parsing: delay and count, then signed values
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_pos <= 5'h0;
            ttt <= 10'h0;
            nexp <= 7'h0;
            vtot <= 7'h0;
            acc <= 24'h0;
            {sel, neg, got_val} <= 3'h0;
        end else if (state == S_IDLE && wr_start) begin
            {ttt, nexp, vtot, acc} <= '0;
            {sel, neg} <= 2'h0;
        end else if (state != S_RECV) begin
            rx_pos <= 5'h0;
            got_val <= 1'b0;
            sel <= 1'b0;
        end else if (rx_valid && !rx_lf) begin
            rx_pos <= rx_pos + 5'h1;
            if (!is_d && rx_digit && rx_pos != 5'h0 && rx_pos <= 5'h3) begin
                ttt <= 10'(ttt * 10 + rx_dv); // RULE6
            end else if (!is_d && rx_digit && rx_pos > 5'h3) begin
                nexp <= 7'(nexp * 10 + rx_dv);
            end else if (is_d && rx_sign) begin
                vtot <= vtot + 7'h1;
                got_val <= 1'b1;
                sel <= hit_idx; // RULE9
                if (hit_idx) neg <= rx_char == CH_MINUS;
            end else if (is_d && rx_digit && sel) begin
                acc <= 24'(acc * 10 + rx_dv); // RULE9
            end
        end
    end
    // ==========================================================
    // line and recording buffer
    sms_line #(.DIV(BAUD_DIV)) u_line (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .tx_char(tx_ch),
        .tx_go(tx_go),
        .tx_rdy(tx_rdy),
        .brk(state == S_BRK),
        .rx_char(rx_char),
        .rx_valid(rx_valid),
        .line_in(sdi_in),
        .line_out(sdi_out),
        .line_oe_n(sdi_oe_n)
    );
    sms_fifo #(.W(32), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .in_valid(state == S_STORE),
        .in_ready(f_in_ready),
        .in_data({bad, 5'h0, cur_ch, bad ? 24'h0 : val}), // RULE12
        .out_valid(f_valid),
        .out_ready(rd_fifo),
        .out_data(f_data),
        .count(f_cnt)
    );
    // ==========================================================
    // register read
    wire [31:0] cfg_word = {8'h0, cfg_idx[cfg_sel], 3'h0, cfg_conc[cfg_sel],
        cfg_dig[cfg_sel], cfg_warm[cfg_sel], cfg_addr[cfg_sel]};
    wire [31:0] stat_word = {16'h0, 8'(f_cnt), state, last_inv, f_valid,
        sensor_pwr, state != S_IDLE};
    wire [31:0] rd_mux =
        reg_addr == A_STAT ? stat_word :
        reg_addr == A_FIFO ? (f_valid ? f_data : 32'h0) :
        cfg_hit ? cfg_word : 32'h0;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) reg_rdata <= 32'h0;
        else reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end
    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    addr_range_a: assert property (c_addr <= ADDR_MAX) // RULE1
        else $error("channel address above nine");
    warm_max_a: assert property (warm_left <= 16'(WARM_MAX_MS)) // RULE2
        else $error("warm-up beyond maximum");
    pwr_on_start_a: assert property ($rose(sensor_pwr) |-> $past(state) == S_IDLE
        && state == S_BRK) // RULE3
        else $error("power rose outside a start");
    cmd_kind_a: assert property (tx_go && tx_pos == 3'h1 && !is_d |->
        tx_ch == CH_M || tx_ch == CH_C) // RULE4
        else $error("wrong measurement command letter");
    fetch_after_a: assert property ($fell(state == S_WAIT) |-> $past(tmr_done)
        || $past(rx_lf)) // RULE7
        else $error("data fetched before delay ended");
    pick_index_a: assert property (push && !bad |-> c_idx != 4'h0
        && {3'h0, c_idx} <= vtot) // RULE9
        else $error("recorded value outside reply");
    short_reply_a: assert property (push && {3'h0, c_idx} > vtot |=> last_inv) // RULE14
        else $error("short reply not flagged");
    pwr_hold_a: assert property ($fell(sensor_pwr) |-> $past(warm_done)
        && $past(state) == S_PWR) // RULE13
        else $error("power removed too early");
    chan_tag_a: assert property (wr_start && state == S_IDLE |=>
        cur_ch == $past(w_ch) ##1 cur_ch == $past(w_ch, 2)) // RULE12
        else $error("channel tag not held");
    good_rec_c: cover property (push && !bad);
    bad_rec_c: cover property (push && bad);
    multi_d_c: cover property (state == S_SEND && is_d && dnum != 4'h0);
endmodule : sms_sequencer

// [test/sms_sensor_model.sv]
`timescale 1ns/1ps
// ==========================================================
// sensor at the far end of the line
module sms_sensor_model
    import sms_pkg::*;
#(
    parameter int BIT = 8,
    parameter logic [6:0] ADDR = 7'h33
) (
    // clock and line
    input wire logic ref_clk,
    input wire logic line,
    output logic drv_n,
    output logic tx,
    // reply shape
    input wire logic [3:0] nvals,
    output logic [6:0] last_cmd,
    output logic last_conc
);
    logic [6:0] c;
    logic [6:0] cmd [8];
    int n;
    // one 7e1 char in, sampled mid-bit
    task getc(output logic [6:0] r);
        @(negedge line);
        repeat (BIT / 2) @(posedge ref_clk);
        for (int i = 0; i < 7; i++) begin
            repeat (BIT) @(posedge ref_clk);
            r[i] = line;
        end
        repeat (2 * BIT) @(posedge ref_clk);
    endtask : getc
    // one 7e1 char out, lsb first, changed on the edge by nba
    task putc(input logic [6:0] v);
        logic [9:0] f;
        f = {1'b1, ^v, v, 1'b0};
        for (int i = 0; i < 10; i++) begin
            tx <= f[i];
            repeat (BIT) @(posedge ref_clk);
        end
    endtask : putc
    // answer only commands that carry our address
    initial begin
        drv_n = 1'b1;
        tx = 1'b1;
        last_cmd = CH_ZERO;
        last_conc = 1'b0;
        forever begin
            getc(c);
            n = 0;
            cmd[0] = c;
            while (c != CH_BANG && c != 7'h00 && n < 7) begin
                getc(c);
                n++;
                cmd[n] = c;
            end
            if (c == 7'h00) begin
                wait (line === 1'b1); // break seen
            end else if (cmd[0] == ADDR) begin
                repeat (2 * BIT) @(posedge ref_clk);
                drv_n <= 1'b0;
                putc(ADDR);
                if (cmd[1] == CH_D) begin
                    for (int k = 1; k <= nvals; k++) begin
                        putc(CH_PLUS);
                        putc(last_cmd);
                        putc(CH_ZERO + 7'(k));
                    end
                end else begin
                    last_cmd = (n == 2) ? CH_ZERO : cmd[2];
                    last_conc = (cmd[1] == CH_C);
                    for (int j = 0; j < 3 + int'(last_conc); j++) begin
                        putc(CH_ZERO);
                    end
                    putc(CH_ZERO + 7'(nvals));
                end
                putc(7'h0d);
                putc(CH_LF);
                drv_n <= 1'b1;
            end
        end
    end
endmodule : sms_sensor_model

// [test/testbench.sv]
`timescale 1ns/1ps
// ==========================================================
// bench top
module testbench;
    import sms_pkg::*;
    typedef struct {logic [31:0] e; logic [31:0] m;} sms_note_t;
    logic ref_clk, reset_n, reg_wr, reg_rd, rd_q, sdi_out, sdi_oe_n, sensor_pwr;
    logic drv_n, tx, last_conc;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [3:0] nvals;
    logic [6:0] last_cmd;
    int n_fail, checks, pw, d, ix, cc;
    sms_note_t q[$];
    // pulled-up shared line
    wire sdi_line = !sdi_oe_n ? sdi_out : (!drv_n ? tx : 1'b1);
    sms_sequencer #(.CLK_PER_MS(20), .BAUD_DIV(8)) u_sms_sequencer (.ref_clk(ref_clk),
        .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sdi_in(sdi_line), .sdi_out(sdi_out),
        .sdi_oe_n(sdi_oe_n), .sensor_pwr(sensor_pwr));
    sms_sensor_model u_sms_sensor_model (.ref_clk(ref_clk), .line(sdi_line), .drv_n(drv_n),
        .tx(tx), .nvals(nvals), .last_cmd(last_cmd), .last_conc(last_conc));
    // 25 mhz clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] cfg(int a, int w, int g, int c, int i);
        return 32'((a << CFG_ADDR) | (w << CFG_WARM) | (g << CFG_DIG) | (c << CFG_CONC)
            | (i << CFG_IDX));
    endfunction : cfg
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            $display("MISMATCH %s exp %h got %h", nm, e, s);
            n_fail++;
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        q.push_back('{e, m});
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
    endtask : rd
    // read data checked against the oldest note
    always @(posedge ref_clk) begin
        if (rd_q) chk("reg_rdata", q[0].e & q[0].m, reg_rdata & q[0].m);
        if (rd_q) q.delete(0);
        rd_q <= reg_rd;
    end
    // one measurement, power-on time counted
    task run(input int ch);
        chk("pwr idle", 32'h0, 32'(sensor_pwr));
        wr(A_CTRL, 32'((ch << CTRL_CH) | 1));
        pw = 0;
        for (int i = 0; i < 30000 && !(pw > 0 && sensor_pwr === 1'b0); i++) begin
            @(posedge ref_clk);
            pw += int'(sensor_pwr === 1'b1);
        end
    endtask : run
    task wrap_up;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    // main sequence
    initial begin
        reset_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        nvals = 4'h3;
        n_fail = 0;
        checks = 0;
        void'($urandom(32'h48e0));
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        rd(A_CFG0 + 8'h04, cfg(CFG_ADDR_RST, CFG_WARM_RST, CFG_DIG_RST, 0, CFG_IDX_RST), '1);
        rd(8'h7c, 32'h0, '1);
        wr(A_CFG0 + 8'h04, cfg(3, 255, 0, 0, 2));
        rd(A_CFG0 + 8'h04, cfg(3, 255, 0, 0, 2), '1);
        wr(A_CFG0 + 8'h04, cfg(10, 1, 9, 0, 2));
        rd(A_CFG0 + 8'h04, cfg(3, 1, 9, 0, 2), '1);
        run(1);
        chk("warm low", 32'h1, 32'(pw >= 4970));
        chk("warm high", 32'h1, 32'(pw <= 5030));
        chk("digit", 32'(CH_NINE), 32'(last_cmd));
        rd(A_FIFO, 32'h0100_005c, '1);
        rd(A_FIFO, 32'h0, '1);
        for (d = 0; d < 10; d++) begin
            cc = $urandom % 2;
            ix = 1 + $urandom % 3;
            wr(A_CFG0 + 8'(4 * (d % 4)), cfg(3, 0, d, cc, ix));
            run(d % 4);
            chk("power off", 32'h1, 32'(pw < 4000));
            chk("digit", 32'(CH_ZERO) + d, 32'(last_cmd));
            chk("command", 32'(cc), 32'(last_conc));
            rd(A_FIFO, 32'(((d % 4) << 24) | (10 * d + ix)), '1);
        end
        wr(A_CFG0 + 8'h08, cfg(3, 0, 1, 0, 5));
        run(2);
        rd(A_FIFO, 32'h8200_0000, '1);
        rd(A_STAT, 32'h8, 32'h8);
        repeat (2) @(posedge ref_clk);
        wrap_up;
    end
    // hang guard
    initial begin
        repeat (90000) @(posedge ref_clk);
        n_fail++;
        wrap_up;
    end
endmodule : testbench
